// [hdl/asc_core.sv]
// Serial control block: registers, transmitter, line routing, pin
// ownership and interrupt request.
// Assumes a single-cycle register port on the bus clock; pin inputs
// are asynchronous and are synchronised here.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// (RULE1) Echo select feeds transmitter into receiver
// (RULE2) Source select ignored without echo select
// (RULE3) Source select picks loopback or single wire
// (RULE4) Halt in wait freezes serial clocks
// (RULE5) Start, 8 or 9 data LSB first, stop
// (RULE6) Wake method: idle line or address mark
// (RULE7) Quiet count starts after start or stop
// (RULE8) Parity generated and checked on MSB
// (RULE9) Parity odd bit selects even or odd
// (RULE10) Buffer empty flag raises enabled interrupt
// (RULE11) Done flag raises enabled interrupt
// (RULE12) Receive full flag raises enabled interrupt
// (RULE13) Quiet line flag raises enabled interrupt
// (RULE14) Transmitter runs only with tx on, owns pin
// (RULE15) Direction bit steers single wire pin
// (RULE16) Tx on toggled queues one idle character
// (RULE17) Pin held until queued traffic finishes
// (RULE18) Receive pin released when off or echoing
// (RULE19) Empty flag set at reset and load
// (RULE20) Done flag set when empty and silent
// (RULE21) Bit rate is clock over sixteen times divisor
// (RULE22) Line idles high, start low, stop high
module asc_core (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  input  wire logic       cpu_wait_i,
  input  wire logic       rx_pin_i,
  input  wire logic       tx_pin_i,
  output logic            tx_pin_o,
  output logic            tx_pin_oe_n_o,
  output logic            rx_pin_own_o,
  output logic            irq_o
);
  typedef struct packed {
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic        tx8;
    logic        dir;
    logic [4:0]  baud_hi;
    logic [12:0] baud;
    logic [8:0]  tx_buf;
    logic        tx_buffer_empty_flag;
    logic        preamble;
    asc_pkg::asc_tx_state_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_sub;
    logic        rx_full;
    logic        quiet;
    logic        perr;
    logic        ferr;
    logic [8:0]  rx_data;
    logic        rx_s1;
    logic        rx_s2;
    logic        txp_s1;
    logic        txp_s2;
    logic        pin;
    logic        oe_n;
    logic        rx_own;
    logic        irq;
    logic [7:0]  rdata;
  } asc_core_t;

  asc_core_t s;
  asc_core_t next_s;
  logic       tick;
  logic       rx_line;
  logic       tc;
  logic       next_tc;
  logic       wr_data;
  logic       own;
  logic       single;
  logic [8:0] rx_word;
  logic       rx_done;
  logic       rx_perr;
  logic       rx_ferr;
  logic       rx_quiet;
  logic       rx_msb;
  logic       accept;

  // Character frame with optional parity in the top data bit
  function automatic logic [10:0] asc_frame(input logic [8:0] d,
                                            input logic nine,
                                            input logic par,
                                            input logic odd);
    logic [8:0] f;
    f = d;
    if (par && nine)
      f[8] = asc_pkg::asc_ones_odd({1'b0, d[7:0]}, 1'b1) ^ odd;
    else if (par)
      f[7] = asc_pkg::asc_ones_odd({2'b00, d[6:0]}, 1'b0) ^ odd;
    asc_frame = nine ? {1'b1, f, 1'b0} : {2'b11, f[7:0], 1'b0};
  endfunction : asc_frame

  // Routing of the receiver input
  assign single = s.ctrl1[asc_pkg::C1_LOOP] && s.ctrl1[asc_pkg::C1_RX_SOURCE_SELECT];
  always_comb
  begin
    if (!s.ctrl1[asc_pkg::C1_LOOP])
      rx_line = s.rx_s2;             // see (RULE1) (RULE2)
    else if (s.ctrl1[asc_pkg::C1_RX_SOURCE_SELECT])
      rx_line = s.txp_s2;            // see (RULE3)
    else
      rx_line = s.pin;               // see (RULE1) (RULE3)
  end

  assign tc = s.tx_buffer_empty_flag && s.tx_st == asc_pkg::TX_IDLE && !s.preamble;
  assign wr_data = wr_i && addr_i == asc_pkg::OFF_DATA;
  assign rx_msb = s.ctrl1[asc_pkg::C1_NINE] ? rx_word[8] : rx_word[7];
  // Standby drops characters until the chosen wake event, see (RULE6)
  assign accept = !s.ctrl2[asc_pkg::C2_STBY] ||
                  (s.ctrl1[asc_pkg::C1_WAKE] && rx_msb);

  // Sample ticks stop in wait mode when asked to, see (RULE4) (RULE21)
  asc_baud #(
    .W(asc_pkg::BAUD_W)
  ) u_baud (
    .clock_i   (clock_i),
    .rstn_i    (rstn_i),
    .divisor_i (s.baud),
    .enable_i  (!(s.ctrl1[asc_pkg::C1_HALT] && cpu_wait_i)),
    .tick_o    (tick)
  );

  asc_rx u_rx (
    .clock_i      (clock_i),
    .rstn_i       (rstn_i),
    .tick_i       (tick),
    .line_i       (rx_line),
    .enable_i     (s.ctrl2[asc_pkg::C2_RXON]),
    .nine_i       (s.ctrl1[asc_pkg::C1_NINE]),
    .par_on_i     (s.ctrl1[asc_pkg::C1_PAR]),
    .par_odd_i    (s.ctrl1[asc_pkg::C1_ODD]),
    .after_stop_i (s.ctrl1[asc_pkg::C1_ILT]),
    .word_o       (rx_word),
    .done_o       (rx_done),
    .perr_o       (rx_perr),
    .ferr_o       (rx_ferr),
    .quiet_o      (rx_quiet)
  );

  // Whole next state: registers, transmitter, flags and pins
  always_comb
  begin
    next_s = s;
    next_s.rx_s1 = rx_pin_i;
    next_s.rx_s2 = s.rx_s1;
    next_s.txp_s1 = tx_pin_i;
    next_s.txp_s2 = s.txp_s1;
    next_s.rdata = 8'h00;
    // Register writes
    if (wr_i)
    begin
      case (addr_i)
        asc_pkg::OFF_BAUD_HI: next_s.baud_hi = wdata_i[4:0];
        asc_pkg::OFF_BAUD_LO: next_s.baud = {s.baud_hi, wdata_i};
        asc_pkg::OFF_CTRL1:   next_s.ctrl1 = wdata_i;
        asc_pkg::OFF_CTRL2:
        begin
          next_s.ctrl2 = wdata_i;
          // Rising tx on queues an idle character, see (RULE16)
          if (!s.ctrl2[asc_pkg::C2_TXON] && wdata_i[asc_pkg::C2_TXON])
            next_s.preamble = 1'b1;
        end
        asc_pkg::OFF_CTRL3:
        begin
          next_s.tx8 = wdata_i[asc_pkg::C3_TX8];
          next_s.dir = wdata_i[asc_pkg::C3_DIR];
        end
        asc_pkg::OFF_DATA:
        begin
          next_s.tx_buf = {s.tx8, wdata_i};
          next_s.tx_buffer_empty_flag = 1'b0;
        end
        default: ;
      endcase
    end
    // Register reads; reading data clears the receive flags
    if (rd_i)
    begin
      case (addr_i)
        asc_pkg::OFF_BAUD_HI: next_s.rdata = {3'h0, s.baud[12:8]};
        asc_pkg::OFF_BAUD_LO: next_s.rdata = s.baud[7:0];
        asc_pkg::OFF_CTRL1:   next_s.rdata = s.ctrl1;
        asc_pkg::OFF_CTRL2:   next_s.rdata = s.ctrl2;
        asc_pkg::OFF_CTRL3:
          next_s.rdata = {s.rx_data[8], s.tx8, s.dir, 5'h00};
        asc_pkg::OFF_STATUS:
          next_s.rdata = {s.tx_buffer_empty_flag, tc, s.rx_full, s.quiet, 2'h0,
                          s.ferr, s.perr};
        asc_pkg::OFF_DATA:
        begin
          next_s.rdata = s.rx_data[7:0];
          next_s.rx_full = 1'b0;
          next_s.quiet = 1'b0;
          next_s.perr = 1'b0;
          next_s.ferr = 1'b0;
        end
        default: next_s.rdata = 8'h00;
      endcase
    end
    // Transmitter engine
    case (s.tx_st)
      asc_pkg::TX_IDLE:
        if (tick && s.preamble)
        begin
          next_s.tx_sh = 11'h7FF;        // All-ones idle character
          next_s.preamble = 1'b0;
          next_s.tx_st = asc_pkg::TX_SHIFT;
          next_s.tx_sub = 4'h0;
          next_s.tx_bits = s.ctrl1[asc_pkg::C1_NINE] ?
                           asc_pkg::FRAME9 : asc_pkg::FRAME8;
        end
        else if (tick && !s.tx_buffer_empty_flag && !wr_data &&
                 s.ctrl2[asc_pkg::C2_TXON]) // see (RULE14)
        begin
          // see (RULE5) (RULE8) (RULE9) (RULE22)
          next_s.tx_sh = asc_frame(s.tx_buf, s.ctrl1[asc_pkg::C1_NINE],
                                   s.ctrl1[asc_pkg::C1_PAR],
                                   s.ctrl1[asc_pkg::C1_ODD]);
          next_s.tx_buffer_empty_flag = 1'b1;            // see (RULE19)
          next_s.tx_st = asc_pkg::TX_SHIFT;
          next_s.tx_sub = 4'h0;
          next_s.tx_bits = s.ctrl1[asc_pkg::C1_NINE] ?
                           asc_pkg::FRAME9 : asc_pkg::FRAME8;
        end
      asc_pkg::TX_SHIFT:
        if (tick)
        begin
          next_s.tx_sub = s.tx_sub + 4'h1;
          if (s.tx_sub == asc_pkg::LAST_SAMPLE)
          begin
            if (s.tx_bits == 4'h1)
              next_s.tx_st = asc_pkg::TX_IDLE;
            else
            begin
              next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
              next_s.tx_bits = s.tx_bits - 4'h1;
            end
          end
        end
      default: next_s.tx_st = asc_pkg::TX_IDLE;
    endcase
    // Received characters; a new event wins over a read clear
    if (rx_done && accept)
    begin
      next_s.rx_data = rx_word;
      next_s.rx_full = 1'b1;
      next_s.perr = rx_perr;
      next_s.ferr = rx_ferr;
      next_s.ctrl2[asc_pkg::C2_STBY] = 1'b0;   // see (RULE6)
    end
    if (rx_quiet)
    begin
      if (!s.ctrl2[asc_pkg::C2_STBY])
        next_s.quiet = 1'b1;
      else if (!s.ctrl1[asc_pkg::C1_WAKE])
        next_s.ctrl2[asc_pkg::C2_STBY] = 1'b0; // see (RULE6)
    end
    // Pins; line idles high between characters
    next_s.pin = (next_s.tx_st == asc_pkg::TX_SHIFT) ?
                 next_s.tx_sh[0] : 1'b1;      // see (RULE22)
    // Ownership lasts until queued traffic drains, see (RULE14) (RULE17)
    own = next_s.ctrl2[asc_pkg::C2_TXON] || next_s.preamble ||
          next_s.tx_st == asc_pkg::TX_SHIFT;
    // Single wire listens unless direction says drive, see (RULE15)
    next_s.oe_n = !(own && (!(next_s.ctrl1[asc_pkg::C1_LOOP] &&
                  next_s.ctrl1[asc_pkg::C1_RX_SOURCE_SELECT]) || next_s.dir));
    next_s.rx_own = next_s.ctrl2[asc_pkg::C2_RXON] &&
                    !next_s.ctrl1[asc_pkg::C1_LOOP]; // see (RULE18)
    // Interrupt request from enabled flags
    next_tc = next_s.tx_buffer_empty_flag && next_s.tx_st == asc_pkg::TX_IDLE &&
              !next_s.preamble;                    // see (RULE20)
    next_s.irq =
      (next_s.ctrl2[asc_pkg::C2_TIE] && next_s.tx_buffer_empty_flag) ||     // see (RULE10)
      (next_s.ctrl2[asc_pkg::C2_TX_DONE_IRQ_ON] && next_tc) ||        // see (RULE11)
      (next_s.ctrl2[asc_pkg::C2_RIE] && next_s.rx_full) ||  // see (RULE12)
      (next_s.ctrl2[asc_pkg::C2_LINE_QUIET_IRQ_ON] && next_s.quiet);     // see (RULE13)
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      s <= '{ctrl1: asc_pkg::CTRL1_RST, ctrl2: asc_pkg::CTRL2_RST,
             baud: asc_pkg::BAUD_RST, tx_buffer_empty_flag: 1'b1,
             tx_st: asc_pkg::TX_IDLE, tx_sh: 11'h7FF, pin: 1'b1,
             oe_n: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1, txp_s1: 1'b1,
             txp_s2: 1'b1, default: '0};
    else
      s <= next_s;
  end

  assign rdata_o = s.rdata;
  assign tx_pin_o = s.pin;
  assign tx_pin_oe_n_o = s.oe_n;
  assign rx_pin_own_o = s.rx_own;
  assign irq_o = s.irq;

  // Checks on routing, timing, flags and pins
  default clocking asc_cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  AST_LOOP_ROUTE: assert property ( // see (RULE1)
    s.ctrl1[asc_pkg::C1_LOOP] && !s.ctrl1[asc_pkg::C1_RX_SOURCE_SELECT]
      |-> rx_line == s.pin)
    else $error("loopback does not feed transmitter output");
  AST_RX_SOURCE_SELECT_IGNORED: assert property ( // see (RULE2)
    !s.ctrl1[asc_pkg::C1_LOOP] |-> rx_line == s.rx_s2)
    else $error("receiver not on its own pin");
  AST_SINGLE_WIRE: assert property ( // see (RULE3)
    single |-> rx_line == s.txp_s2)
    else $error("single wire receiver not on shared pin");
  AST_FREEZE: assert property ( // see (RULE4)
    s.ctrl1[asc_pkg::C1_HALT] && cpu_wait_i ##1
      s.ctrl1[asc_pkg::C1_HALT] && cpu_wait_i |-> !tick)
    else $error("sample tick while frozen");
  AST_BAUD_OFF: assert property ( // see (RULE21)
    s.baud == 13'h0000 ##1 s.baud == 13'h0000 |-> !tick)
    else $error("tick with zero divisor");
  AST_START_LOW: assert property ( // see (RULE22)
    $rose(s.tx_st == asc_pkg::TX_SHIFT) && !$past(s.preamble)
      |-> !tx_pin_o [*8])
    else $error("start bit not low");
  AST_TX_GATED: assert property ( // see (RULE14)
    s.tx_st == asc_pkg::TX_IDLE && !s.preamble &&
      !s.ctrl2[asc_pkg::C2_TXON] |=> s.tx_st == asc_pkg::TX_IDLE)
    else $error("transmitter started while off");
  AST_PIN_HELD: assert property ( // see (RULE17)
    s.tx_st == asc_pkg::TX_SHIFT && !single |-> !tx_pin_oe_n_o)
    else $error("pin released during a character");
  AST_RX_PIN: assert property ( // see (RULE18)
    s.ctrl1[asc_pkg::C1_LOOP] |-> !rx_pin_own_o)
    else $error("receive pin kept while echoing");
  AST_TX_BUFFER_EMPTY_FLAG_LOAD: assert property ( // see (RULE19)
    $rose(s.tx_st == asc_pkg::TX_SHIFT) && !$past(s.preamble)
      |-> s.tx_buffer_empty_flag && !$past(s.tx_buffer_empty_flag))
    else $error("empty flag not set on load");
  AST_IRQ_DONE: assert property ( // see (RULE11)
    s.ctrl2[asc_pkg::C2_TX_DONE_IRQ_ON] && tc |-> irq_o)
    else $error("done interrupt missing");
  AST_IRQ_QUIET: assert property ( // see (RULE13)
    irq_o && !(s.ctrl2[asc_pkg::C2_TIE] && s.tx_buffer_empty_flag) &&
      !(s.ctrl2[asc_pkg::C2_TX_DONE_IRQ_ON] && tc) &&
      !(s.ctrl2[asc_pkg::C2_RIE] && s.rx_full)
      |-> s.quiet && s.ctrl2[asc_pkg::C2_LINE_QUIET_IRQ_ON])
    else $error("interrupt without a cause");
endmodule : asc_core
`default_nettype wire

// [hdl/asc_pkg.sv]
// Constants and types shared by the serial control block.
// Assumes an 8-bit register port and one bus clock.
package asc_pkg;
  localparam int unsigned ADDR_W  = 3;
  localparam int unsigned BAUD_W  = 13;
  // Register offsets
  localparam logic [2:0] OFF_BAUD_HI = 3'h0;
  localparam logic [2:0] OFF_BAUD_LO = 3'h1;
  localparam logic [2:0] OFF_CTRL1   = 3'h2;
  localparam logic [2:0] OFF_CTRL2   = 3'h3;
  localparam logic [2:0] OFF_STATUS  = 3'h4;
  localparam logic [2:0] OFF_DATA    = 3'h5;
  localparam logic [2:0] OFF_CTRL3   = 3'h6;
  // serial_control_one fields
  localparam int unsigned C1_LOOP  = 7;
  localparam int unsigned C1_HALT  = 6;
  localparam int unsigned C1_RX_SOURCE_SELECT  = 5;
  localparam int unsigned C1_NINE  = 4;
  localparam int unsigned C1_WAKE  = 3;
  localparam int unsigned C1_ILT   = 2;
  localparam int unsigned C1_PAR   = 1;
  localparam int unsigned C1_ODD   = 0;
  // serial_control_two fields
  localparam int unsigned C2_TIE   = 7;
  localparam int unsigned C2_TX_DONE_IRQ_ON  = 6;
  localparam int unsigned C2_RIE   = 5;
  localparam int unsigned C2_LINE_QUIET_IRQ_ON  = 4;
  localparam int unsigned C2_TXON  = 3;
  localparam int unsigned C2_RXON  = 2;
  localparam int unsigned C2_STBY  = 1;
  // Third control register and status fields
  localparam int unsigned C3_RX8   = 7;
  localparam int unsigned C3_TX8   = 6;
  localparam int unsigned C3_DIR   = 5;
  localparam int unsigned ST_TX_BUFFER_EMPTY_FLAG  = 7;
  localparam int unsigned ST_TC    = 6;
  localparam int unsigned ST_RXF   = 5;
  localparam int unsigned ST_QUIET = 4;
  localparam int unsigned ST_FERR  = 1;
  localparam int unsigned ST_PERR  = 0;
  // Reset values
  localparam logic [7:0]  CTRL1_RST = 8'h00;
  localparam logic [7:0]  CTRL2_RST = 8'h00;
  localparam logic [12:0] BAUD_RST  = 13'h0004;
  // Bit timing in sample ticks and bit counts
  localparam logic [3:0] MID_SAMPLE  = 4'h7;
  localparam logic [3:0] LAST_SAMPLE = 4'hF;
  localparam logic [3:0] FRAME8      = 4'hA;
  localparam logic [3:0] FRAME9      = 4'hB;
  localparam logic [3:0] DATA8       = 4'h8;
  localparam logic [3:0] DATA9       = 4'h9;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } asc_tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } asc_rx_state_t;

  // Odd ones count of the data bits of a character, 8 or 9 wide
  function automatic logic asc_ones_odd(input logic [8:0] d,
                                        input logic nine);
    asc_ones_odd = nine ? ^d : ^d[7:0];
  endfunction : asc_ones_odd
endpackage : asc_pkg

// [hdl/asc_baud.sv]
// Baud generator: one sample tick every divisor clocks, sixteen per bit.
// Assumes divisor and enable come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module asc_baud #(
  parameter int unsigned W = asc_pkg::BAUD_W
) (
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] divisor_i,
  input  wire logic         enable_i,
  output logic              tick_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } asc_baud_t;

  asc_baud_t s;
  asc_baud_t next_s;

  // Zero divisor or a frozen clock stops the ticks
  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (divisor_i == '0 || !enable_i)
    begin
      next_s.cnt = '0;
    end
    else if (s.cnt >= divisor_i - W'(1))
    begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick_o = s.tick;
endmodule : asc_baud
`default_nettype wire

// [hdl/asc_rx.sv]
// Receiver: samples the routed line at sixteen ticks per bit, checks
// parity and stop bit, and detects a quiet line.
// Assumes the line input is already synchronised to the clock.
`timescale 1ns/10ps
`default_nettype none
module asc_rx (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       tick_i,
  input  wire logic       line_i,
  input  wire logic       enable_i,
  input  wire logic       nine_i,
  input  wire logic       par_on_i,
  input  wire logic       par_odd_i,
  input  wire logic       after_stop_i,
  output logic [8:0]      word_o,
  output logic            done_o,
  output logic            perr_o,
  output logic            ferr_o,
  output logic            quiet_o
);
  typedef struct packed {
    asc_pkg::asc_rx_state_t st;
    logic [3:0] sub;
    logic [3:0] bits;
    logic [8:0] sh;
    logic [8:0] word;
    logic       done;
    logic       perr;
    logic       ferr;
    logic       quiet;
    logic [3:0] qsub;
    logic [3:0] qcnt;
    logic       armed;
  } asc_rx_t;

  asc_rx_t s;
  asc_rx_t next_s;
  logic [3:0] dlen;
  logic [3:0] qlim;

  assign dlen = nine_i ? asc_pkg::DATA9 : asc_pkg::DATA8;
  assign qlim = nine_i ? asc_pkg::FRAME9 : asc_pkg::FRAME8;

  // Character framing and quiet-line counting
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.quiet = 1'b0;
    if (!enable_i)
    begin
      next_s.st = asc_pkg::RX_IDLE;
      next_s.armed = 1'b0;
    end
    else if (tick_i)
    begin
      next_s.sub = s.sub + 4'h1;
      case (s.st)
        asc_pkg::RX_IDLE:
          if (!line_i)
          begin
            next_s.st = asc_pkg::RX_START;
            next_s.sub = 4'h0;
          end
        asc_pkg::RX_START:
          if (s.sub == asc_pkg::MID_SAMPLE)
          begin
            next_s.sub = 4'h0;
            next_s.bits = 4'h0;
            next_s.sh = '0;
            // A short low is noise, not a start bit
            next_s.st = line_i ? asc_pkg::RX_IDLE : asc_pkg::RX_DATA;
          end
        asc_pkg::RX_DATA:
          if (s.sub == asc_pkg::LAST_SAMPLE)
          begin
            next_s.sh[s.bits] = line_i; // LSB first, see (RULE5)
            next_s.bits = s.bits + 4'h1;
            if (s.bits + 4'h1 == dlen)
              next_s.st = asc_pkg::RX_STOP;
          end
        asc_pkg::RX_STOP:
          if (s.sub == asc_pkg::LAST_SAMPLE)
          begin
            next_s.st = asc_pkg::RX_IDLE;
            next_s.word = s.sh;
            next_s.done = 1'b1;
            next_s.ferr = !line_i; // see (RULE22)
            // see (RULE8) (RULE9)
            next_s.perr = par_on_i &&
              (asc_pkg::asc_ones_odd(s.sh, nine_i) != par_odd_i);
          end
        default: next_s.st = asc_pkg::RX_IDLE;
      endcase
      // Quiet count start point, see (RULE7)
      if (!line_i || (after_stop_i && s.st != asc_pkg::RX_IDLE))
      begin
        next_s.qsub = 4'h0;
        next_s.qcnt = 4'h0;
        if (!line_i)
          next_s.armed = 1'b1;
      end
      else if (s.st != asc_pkg::RX_START)
      begin
        next_s.qsub = s.qsub + 4'h1;
        if (s.qsub == asc_pkg::LAST_SAMPLE && s.qcnt != qlim)
          next_s.qcnt = s.qcnt + 4'h1;
      end
      if (s.armed && s.qcnt == qlim)
      begin
        next_s.quiet = 1'b1;
        next_s.armed = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      s <= '{st: asc_pkg::RX_IDLE, default: '0};
    else
      s <= next_s;
  end

  assign word_o  = s.word;
  assign done_o  = s.done;
  assign perr_o  = s.perr;
  assign ferr_o  = s.ferr;
  assign quiet_o = s.quiet;
endmodule : asc_rx
`default_nettype wire

// [verif/asc_peer.sv]
// Remote serial peer: sends frames on the receive pin, captures tx.
// Assumes divisor 1, so sixteen clocks make one bit.
`timescale 1ns/10ps
`default_nettype none
module asc_peer (
  input  wire logic clock_i,
  input  wire logic line_i,
  output logic      line_o
);
  localparam int BIT = 16;
  // Line rests high between frames
  initial line_o = 1'b1;
  // Start low, data LSB first, stop high
  task automatic send(input logic [8:0] d, input int n);
    line_o <= 1'b0;
    repeat (BIT) @(posedge clock_i);
    for (int i = 0; i < n; i++)
    begin
      line_o <= d[i];
      repeat (BIT) @(posedge clock_i);
    end
    line_o <= 1'b1;
    repeat (BIT) @(posedge clock_i);
  endtask : send
  // Mid-bit samples; a missing start leaves bit 0 high
  task automatic recv(input int n, output logic [10:0] f);
    int t = 0;
    f = '1;
    while (line_i !== 1'b0 && t < 4000)
    begin
      @(posedge clock_i);
      t++;
    end
    repeat (BIT / 2) @(posedge clock_i);
    for (int i = 0; i <= n + 1; i++)
    begin
      f[i] = line_i;
      repeat (BIT) @(posedge clock_i);
    end
  endtask : recv
endmodule : asc_peer
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the serial control block.
// Assumes asc_core with a peer model on its serial pins.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clock_i;
  logic        rstn_i;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        cpu_wait;
  logic [7:0]  rdata;
  logic        rx_line;
  logic        tx_wire;
  logic        tx_pin;
  logic        tx_oe_n;
  logic        rx_own;
  logic        irq;
  int          err_count;
  int          total_checks;
  logic [10:0] f;
  logic [8:0]  e;
  logic [7:0]  m;
  logic [7:0]  modes [6] = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h12, 8'h13};
  // Pull-up holds the tx wire high when released
  assign tx_wire = tx_oe_n ? 1'b1 : tx_pin;
  asc_core asc_core_inst (.clock_i(clock_i), .rstn_i(rstn_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .cpu_wait_i(cpu_wait), .rx_pin_i(rx_line),
    .tx_pin_i(tx_wire), .tx_pin_o(tx_pin), .tx_pin_oe_n_o(tx_oe_n),
    .rx_pin_own_o(rx_own), .irq_o(irq));
  asc_peer asc_peer_inst (.clock_i(clock_i), .line_i(tx_wire),
    .line_o(rx_line));
  // 250 MHz bus clock
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic chk(input string n, input logic [10:0] x,
                     input logic [10:0] g);
    total_checks++;
    if (g !== x)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask : wr_reg
  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] x);
    logic [7:0] d;
    rd_reg(a, d);
    chk("register", x, d);
  endtask : rd_chk
  task automatic settle;
    repeat (2) @(posedge clock_i);
    #1;
  endtask : settle
  task automatic complete_run;
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // Watchdog, far beyond the few thousand cycles the tests need
  initial
  begin
    #100000;
    err_count++;
    complete_run();
  end
  // Test sequence
  initial
  begin
    rstn_i = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    cpu_wait = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd_chk(asc_pkg::OFF_CTRL1, 8'h00);
    rd_chk(asc_pkg::OFF_CTRL2, 8'h00);
    rd_chk(asc_pkg::OFF_STATUS, 8'hC0);
    rd_chk(3'h7, 8'h00);
    chk("oe_n", 1, tx_oe_n);
    wr_reg(asc_pkg::OFF_BAUD_HI, 8'h00);
    wr_reg(asc_pkg::OFF_BAUD_LO, 8'h01);
    wr_reg(asc_pkg::OFF_CTRL3, 8'h40);
    wr_reg(asc_pkg::OFF_CTRL2, 8'h0C);
    settle();
    chk("oe_n", 0, tx_oe_n);
    chk("rx_own", 1, rx_own);
    // Every framing and parity mode, MSB replaced by parity
    foreach (modes[i])
    begin
      m = modes[i];
      e = 9'h1B5;
      if (m[1] && m[4])
        e[8] = ^e[7:0] ^ m[0];
      if (m[1] && !m[4])
        e[7] = ^e[6:0] ^ m[0];
      wr_reg(asc_pkg::OFF_CTRL1, m);
      wr_reg(asc_pkg::OFF_DATA, 8'hB5);
      asc_peer_inst.recv(m[4] ? 9 : 8, f);
      chk("tx frame", m[4] ? {1'b1, e, 1'b0} : {2'b11, e[7:0], 1'b0},
          f);
    end
    wr_reg(asc_pkg::OFF_CTRL2, 8'h8C);
    settle();
    chk("irq", 1, irq);
    wr_reg(asc_pkg::OFF_CTRL2, 8'h4C);
    settle();
    chk("irq", 1, irq);
    wr_reg(asc_pkg::OFF_CTRL2, 8'h0C);
    settle();
    chk("irq", 0, irq);
    // Frozen clocks hold a written character back until wait ends
    wr_reg(asc_pkg::OFF_CTRL1, 8'h40);
    cpu_wait <= 1'b1;
    wr_reg(asc_pkg::OFF_DATA, 8'h5A);
    repeat (6) @(posedge clock_i);
    settle();
    chk("frozen line", 1, tx_wire);
    @(posedge clock_i);
    cpu_wait <= 1'b0;
    asc_peer_inst.recv(8, f);
    chk("tx frame", {2'b11, 8'h5A, 1'b0}, f);
    // Receive with even parity, good then bad; source bit alone is inert
    wr_reg(asc_pkg::OFF_CTRL1, 8'h22);
    wr_reg(asc_pkg::OFF_CTRL2, 8'h2C);
    asc_peer_inst.send(9'h035, 8);
    settle();
    chk("irq", 1, irq);
    rd_reg(asc_pkg::OFF_STATUS, m);
    chk("status", 8'h20, m & 8'h21);
    rd_chk(asc_pkg::OFF_DATA, 8'h35);
    settle();
    chk("irq", 0, irq);
    asc_peer_inst.send(9'h0B5, 8);
    rd_reg(asc_pkg::OFF_STATUS, m);
    chk("status", 8'h21, m & 8'h21);
    rd_chk(asc_pkg::OFF_DATA, 8'hB5);
    // Pin held while the character in flight finishes
    wr_reg(asc_pkg::OFF_CTRL2, 8'h0C);
    wr_reg(asc_pkg::OFF_DATA, 8'h35);
    repeat (8) @(posedge clock_i);
    wr_reg(asc_pkg::OFF_CTRL2, 8'h04);
    settle();
    chk("oe_n", 0, tx_oe_n);
    repeat (400) @(posedge clock_i);
    chk("oe_n", 1, tx_oe_n);
    // Quiet line has long followed the last received character
    wr_reg(asc_pkg::OFF_CTRL2, 8'h14);
    settle();
    chk("irq", 1, irq);
    // Loopback ignores a receive pin held low
    wr_reg(asc_pkg::OFF_CTRL2, 8'h0C);
    wr_reg(asc_pkg::OFF_CTRL1, 8'h80);
    asc_peer_inst.line_o <= 1'b0;
    settle();
    chk("rx_own", 0, rx_own);
    repeat (200) @(posedge clock_i);
    wr_reg(asc_pkg::OFF_DATA, 8'h5A);
    repeat (200) @(posedge clock_i);
    rd_chk(asc_pkg::OFF_DATA, 8'h5A);
    // Single wire direction steers the shared pin
    wr_reg(asc_pkg::OFF_CTRL1, 8'hA0);
    wr_reg(asc_pkg::OFF_CTRL3, 8'h00);
    settle();
    chk("oe_n", 1, tx_oe_n);
    wr_reg(asc_pkg::OFF_CTRL3, 8'h20);
    settle();
    chk("oe_n", 0, tx_oe_n);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
